// [rtl/irq_ctrl.v]
// four level interrupt controller with two external request pins
// Functional notes
// - twelve sources, each given one of four priority levels
// - per source enable, plus a global enable in enable register A
// - service is preempted only by a strictly higher level
// - a top-level routine cannot be interrupted at all
// - of different levels arriving together, the higher is taken
// - fixed ranking decides only among requests of equal level
// - ranking order from external 0 down to the timeout timer
// - each source presents its own fixed vector address
// - enable bit positions in enable registers A and B
// - level is high-half bit and low-half bit at the enable position
// - only externals, brownout, keypad, comparators, watchdog wake
// - level mode: low pin level requests the interrupt
// - edge mode: high sample then low sample sets the flag
// - edge flag clears when its service routine is entered
// - level source holds until taken; still low re-raises it
// - level flag tracks the pin and needs no clearing
// - enabled external request wakes from power down or idle
// - keypad flag stays set until software clears it
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_consts.vh"

module irq_ctrl (
  // clock and reset
  input wire CLK,
  input wire RST_B,
  // register port
  input wire [3:0] ADDR,
  input wire [7:0] WR_DATA,
  input wire WR_EN,
  input wire RD_EN,
  output reg [7:0] RD_DATA,
  // external request pins, active low
  input wire EXT_IRQ_PIN_ZERO_N,
  input wire EXT_IRQ_PIN_ONE_N,
  // peripheral request levels
  input wire TIMER_ZERO_OVERFLOW_FLAG,
  input wire TIMER_ONE_OVERFLOW_FLAG,
  input wire SERIAL_TX_FLAG,
  input wire SERIAL_RX_FLAG,
  input wire BROWNOUT_FLAG,
  input wire WATCHDOG_OVERFLOW_FLAG,
  input wire SERIAL_BUS_ATTENTION_FLAG,
  input wire COMPARATOR_TWO_FLAG,
  input wire COMPARATOR_ONE_FLAG,
  input wire TIMEOUT_TIMER_FLAG,
  // keypad event pulse, latched here
  input wire KEYPAD_EVENT,
  // processor core handshake
  input wire IRQ_ACK,
  input wire IRQ_RETURN,
  output reg IRQ_REQ,
  output reg [15:0] IRQ_VECTOR,
  output reg [1:0] IRQ_LEVEL,
  output reg WAKE_REQ
);

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // index of the highest in-service level, valid when mask non zero
  function [1:0] top_level;
    input [3:0] mask;
    begin
      top_level = 2'd0;
      if (mask[1])
        top_level = 2'd1;
      if (mask[2])
        top_level = 2'd2;
      if (mask[3])
        top_level = 2'd3;
    end
  endfunction

  // vector address of a source
  function [15:0] vec_of;
    input [3:0] idx;
    begin
      case (idx)
        4'd0: vec_of = `VEC_0;
        4'd1: vec_of = `VEC_1;
        4'd2: vec_of = `VEC_2;
        4'd3: vec_of = `VEC_3;
        4'd4: vec_of = `VEC_4;
        4'd5: vec_of = `VEC_5;
        4'd6: vec_of = `VEC_6;
        4'd7: vec_of = `VEC_7;
        4'd8: vec_of = `VEC_8;
        4'd9: vec_of = `VEC_9;
        4'd10: vec_of = `VEC_10;
        default: vec_of = `VEC_11;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers and state

  reg [7:0] en_a_q;
  reg [7:0] en_b_q;
  reg [7:0] plo_a_q;
  reg [7:0] phi_a_q;
  reg [7:0] plo_b_q;
  reg [7:0] phi_b_q;
  reg [7:0] trig_q;
  reg [2:0] mc_cnt_q;
  reg [1:0] pin_smp_q;
  reg ext_flag_zero_q;
  reg ext_flag_one_q;
  reg keypad_flag_q;
  reg [3:0] in_service_q;
  reg [3:0] win_idx_q;
  reg [7:0] rd_d;

  wire wr_flags;
  wire sample_tick;
  wire [1:0] pin_low;
  wire [11:0] flags;
  wire [11:0] src_en;
  wire [11:0] plo;
  wire [11:0] phi;
  wire [11:0] active;
  wire global_en;
  wire [47:0] ranks_all = `RANKS;

  assign wr_flags = WR_EN && (ADDR == `OFS_FLAGS);
  assign sample_tick = (mc_cnt_q == `MC_LAST);
  assign pin_low = {~EXT_IRQ_PIN_ONE_N, ~EXT_IRQ_PIN_ZERO_N};
  assign global_en = en_a_q[`BIT_GLOBAL];

  // per source enable and priority bits gathered by source index
  assign src_en = {en_b_q[7], en_b_q[5], en_b_q[2:0], en_a_q[6:0]};
  assign plo = {plo_b_q[7], plo_b_q[5], plo_b_q[2:0], plo_a_q[6:0]};
  assign phi = {phi_b_q[7], phi_b_q[5], phi_b_q[2:0], phi_a_q[6:0]};

  // request flags by source index, visible whatever the enables
  assign flags = {TIMEOUT_TIMER_FLAG, COMPARATOR_ONE_FLAG,
                  COMPARATOR_TWO_FLAG, keypad_flag_q,
                  SERIAL_BUS_ATTENTION_FLAG, WATCHDOG_OVERFLOW_FLAG,
                  BROWNOUT_FLAG, SERIAL_TX_FLAG | SERIAL_RX_FLAG,
                  TIMER_ONE_OVERFLOW_FLAG, ext_flag_one_q,
                  TIMER_ZERO_OVERFLOW_FLAG, ext_flag_zero_q};
  assign active = flags & src_en & {`SRC_NUM{global_en}};

  ////////////////////////////////////////////////////////////////////////
  // winner search: highest level, then best rank

  reg [3:0] best_idx;
  reg [1:0] best_lvl;
  reg [3:0] best_rank;
  reg best_found;
  reg [1:0] cur_lvl;
  reg [3:0] cur_rank;
  reg allow;
  integer i;

  always @*
  begin
    best_idx = 4'd0;
    best_lvl = 2'd0;
    best_rank = 4'hf;
    best_found = 1'b0;
    cur_lvl = 2'd0;
    cur_rank = 4'd0;
    for (i = 0; i < `SRC_NUM; i = i + 1)
    begin
      cur_lvl = {phi[i], plo[i]};
      cur_rank = ranks_all[4 * i +: 4];
      if (active[i] && (!best_found || cur_lvl > best_lvl ||
          (cur_lvl == best_lvl && cur_rank < best_rank)))
      begin
        best_idx = i[3:0];
        best_lvl = cur_lvl;
        best_rank = cur_rank;
        best_found = 1'b1;
      end
    end
    // strictly above the innermost level in service
    allow = best_found && (in_service_q == 4'h0 ||
            best_lvl > top_level(in_service_q));
  end

  ////////////////////////////////////////////////////////////////////////
  // core handshake, in-service record and wake

  // request withheld in the acknowledge cycle so a stale one never shows
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      IRQ_REQ <= 1'b0;
      IRQ_VECTOR <= 16'h0000;
      IRQ_LEVEL <= 2'd0;
      win_idx_q <= 4'd0;
      in_service_q <= 4'h0;
      WAKE_REQ <= 1'b0;
    end
    else
    begin
      IRQ_REQ <= allow && !IRQ_ACK;
      IRQ_VECTOR <= vec_of(best_idx);
      IRQ_LEVEL <= best_lvl;
      win_idx_q <= best_idx;
      WAKE_REQ <= |(active & `WAKE_MASK);
      if (IRQ_ACK && IRQ_REQ)
        in_service_q <= in_service_q | (4'h1 << IRQ_LEVEL);
      else if (IRQ_RETURN && in_service_q != 4'h0)
        in_service_q <= in_service_q &
                        ~(4'h1 << top_level(in_service_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external pins: machine cycle sampling and request flags

  wire take_ext0;
  wire take_ext1;
  wire [1:0] fall;

  assign take_ext0 = IRQ_ACK && IRQ_REQ && win_idx_q == `SRC_EXT0;
  assign take_ext1 = IRQ_ACK && IRQ_REQ && win_idx_q == `SRC_EXT1;
  // previous sample high (not low) and new sample low
  assign fall = ~pin_smp_q & pin_low;

  // one sample every machine cycle of six clocks
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      mc_cnt_q <= 3'd0;
      pin_smp_q <= 2'b00;
      ext_flag_zero_q <= 1'b0;
      ext_flag_one_q <= 1'b0;
    end
    else
    begin
      mc_cnt_q <= sample_tick ? 3'd0 : mc_cnt_q + 3'd1;
      if (sample_tick)
        pin_smp_q <= pin_low;
      // external 0: level tracks pin, edge sets and clears on entry
      if (!trig_q[0])
      begin
        if (sample_tick)
          ext_flag_zero_q <= pin_low[0];
      end
      else if (sample_tick && fall[0])
        ext_flag_zero_q <= 1'b1;
      else if (take_ext0)
        ext_flag_zero_q <= 1'b0;
      // external 1: same behaviour
      if (!trig_q[1])
      begin
        if (sample_tick)
          ext_flag_one_q <= pin_low[1];
      end
      else if (sample_tick && fall[1])
        ext_flag_one_q <= 1'b1;
      else if (take_ext1)
        ext_flag_one_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // keypad flag: set by event, cleared only by software, set wins

  always @(posedge CLK)
  begin
    if (!RST_B)
      keypad_flag_q <= 1'b0;
    else if (KEYPAD_EVENT)
      keypad_flag_q <= 1'b1;
    else if (wr_flags && WR_DATA[`BIT_KEYPAD_CLR])
      keypad_flag_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes

  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      en_a_q <= `RST_BYTE;
      en_b_q <= `RST_BYTE;
      plo_a_q <= `RST_BYTE;
      phi_a_q <= `RST_BYTE;
      plo_b_q <= `RST_BYTE;
      phi_b_q <= `RST_BYTE;
      trig_q <= `RST_BYTE;
    end
    else if (WR_EN)
    begin
      case (ADDR)
        `OFS_EN_A: en_a_q <= WR_DATA & `MASK_A;
        `OFS_EN_B: en_b_q <= WR_DATA & `MASK_B;
        `OFS_PLO_A: plo_a_q <= WR_DATA & `MASK_A;
        `OFS_PHI_A: phi_a_q <= WR_DATA & `MASK_A;
        `OFS_PLO_B: plo_b_q <= WR_DATA & `MASK_B;
        `OFS_PHI_B: phi_b_q <= WR_DATA & `MASK_B;
        `OFS_TRIG: trig_q <= WR_DATA & `MASK_TRIG;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads, data in the following cycle only

  always @*
  begin
    case (ADDR)
      `OFS_EN_A: rd_d = en_a_q;
      `OFS_EN_B: rd_d = en_b_q;
      `OFS_PLO_A: rd_d = plo_a_q;
      `OFS_PHI_A: rd_d = phi_a_q;
      `OFS_PLO_B: rd_d = plo_b_q;
      `OFS_PHI_B: rd_d = phi_b_q;
      `OFS_TRIG: rd_d = trig_q;
      `OFS_FLAGS: rd_d = {5'h00, keypad_flag_q, ext_flag_one_q,
                          ext_flag_zero_q};
      `OFS_STATUS: rd_d = {IRQ_REQ, IRQ_LEVEL, 1'b0, in_service_q};
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge CLK)
  begin
    if (!RST_B)
      RD_DATA <= 8'h00;
    else
      RD_DATA <= RD_EN ? rd_d : 8'h00;
  end

endmodule // irq_ctrl

`default_nettype wire

// [pkg/irq_ctrl_consts.vh]
// constants for the four level interrupt controller
`ifndef IRQ_CTRL_CONSTS_VH
`define IRQ_CTRL_CONSTS_VH

// register offsets on the plain register port
`define OFS_EN_A 4'h0
`define OFS_EN_B 4'h1
`define OFS_PLO_A 4'h2
`define OFS_PHI_A 4'h3
`define OFS_PLO_B 4'h4
`define OFS_PHI_B 4'h5
`define OFS_TRIG 4'h6
`define OFS_FLAGS 4'h7
`define OFS_STATUS 4'h8

// reset values and implemented bit masks
`define RST_BYTE 8'h00
`define MASK_A 8'hff
`define MASK_B 8'ha7
`define MASK_TRIG 8'h03
`define BIT_GLOBAL 7
`define BIT_KEYPAD_CLR 2

// source indices (enable bit order)
`define SRC_EXT0 4'd0
`define SRC_EXT1 4'd2
`define SRC_NUM 12

// last clock count of the machine cycle, which is six cpu clocks long
`define MC_LAST 3'd5

// fixed tie-break ranks, 4 bits per source, source 0 in low bits
`define RANKS 48'hd_9_b_8_5_3_2_c_a_7_4_1
// sources able to wake from power down
`define WAKE_MASK 12'h765

// vector addresses
`define VEC_0 16'h0003
`define VEC_1 16'h000b
`define VEC_2 16'h0013
`define VEC_3 16'h001b
`define VEC_4 16'h0023
`define VEC_5 16'h002b
`define VEC_6 16'h0053
`define VEC_7 16'h0033
`define VEC_8 16'h003b
`define VEC_9 16'h0043
`define VEC_10 16'h0063
`define VEC_11 16'h0073

`endif

// [verification/irq_ctrl_assertions.sv]
// port checker for the four level interrupt controller
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_assertions (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic RD_EN,
  input wire logic [7:0] RD_DATA,
  // core handshake
  input wire logic IRQ_ACK,
  input wire logic IRQ_RETURN,
  input wire logic IRQ_REQ,
  input wire logic [15:0] IRQ_VECTOR,
  input wire logic [1:0] IRQ_LEVEL,
  input wire logic WAKE_REQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic top_q;
  logic [1:0] lv_q;
  // track a top-level routine and the level last taken
  always @(posedge CLK)
    if (!RST_B || IRQ_RETURN)
      top_q <= 1'b0;
    else if (IRQ_ACK && IRQ_REQ && IRQ_LEVEL == 2'h3)
      top_q <= 1'b1;
  always @(posedge CLK)
    if (!RST_B)
      lv_q <= 2'h0;
    else if (IRQ_ACK && IRQ_REQ)
      lv_q <= IRQ_LEVEL;
  a_top_blocks: assert property (top_q |-> !IRQ_REQ)
    else $error("request shown during top-level service");
  a_ack_drops: assert property (IRQ_ACK && IRQ_REQ |=> !IRQ_REQ)
    else $error("request still shown after acknowledge");
  a_level_block: assert property (IRQ_ACK && IRQ_REQ |=>
    (!IRQ_REQ || IRQ_LEVEL > lv_q) [*4])
    else $error("equal or lower level presented in service");
  a_vector_known: assert property (IRQ_REQ |-> IRQ_VECTOR inside
    {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
    16'h0033, 16'h003b, 16'h0043, 16'h0053, 16'h0063, 16'h0073})
    else $error("vector outside the table");
  a_regb_holes: assert property (RD_EN && ADDR == 4'h1 |=>
    (RD_DATA & 8'h58) == 8'h00)
    else $error("unused enable bit reads one");
  a_prio_holes: assert property (RD_EN && (ADDR == 4'h4 ||
    ADDR == 4'h5) |=> (RD_DATA & 8'h58) == 8'h00)
    else $error("unused priority bit reads one");
  a_trig_holes: assert property (RD_EN && ADDR == 4'h6 |=>
    RD_DATA[7:2] == 6'h00)
    else $error("unused trigger bit reads one");
  a_reset_quiet: assert property (disable iff (1'b0) !RST_B |=>
    !IRQ_REQ && !WAKE_REQ)
    else $error("request or wake out of reset");
endmodule // irq_ctrl_assertions
bind irq_ctrl irq_ctrl_assertions chk (.CLK, .RST_B, .ADDR, .RD_EN,
  .RD_DATA, .IRQ_ACK, .IRQ_RETURN, .IRQ_REQ, .IRQ_VECTOR, .IRQ_LEVEL,
  .WAKE_REQ);
`default_nettype wire

// [verification/core_model.sv]
// processor core model answering the request handshake
`timescale 1ns/1ns
`default_nettype none
module core_model (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // controller side
  input wire logic IRQ_REQ,
  input wire logic [15:0] IRQ_VECTOR,
  output logic IRQ_ACK,
  output logic IRQ_RETURN,
  // bench control, take held low stalls the answer
  input wire logic take,
  input wire logic ret_go,
  output logic [15:0] last_vec
);
  // one ack per shown request, return on command
  always @(posedge CLK)
    if (!RST_B)
    begin
      IRQ_ACK <= 1'b0;
      IRQ_RETURN <= 1'b0;
      last_vec <= 16'h0000;
    end
    else
    begin
      IRQ_ACK <= take && IRQ_REQ && !IRQ_ACK;
      IRQ_RETURN <= ret_go;
      if (IRQ_ACK && IRQ_REQ)
        last_vec <= IRQ_VECTOR;
    end
endmodule // core_model
`default_nettype wire

// [verification/irq_ctrl_tb.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_tb;
  logic CLK, RST_B, WR_EN, RD_EN, take, ret_go, IRQ_ACK, IRQ_RETURN;
  logic IRQ_REQ, WAKE_REQ, rx;
  logic [3:0] ADDR;
  logic [7:0] WR_DATA, RD_DATA, v;
  logic [11:0] src;
  logic [15:0] IRQ_VECTOR, last_vec;
  logic [1:0] IRQ_LEVEL;
  int n_fail, n_compared, cyc;
  logic [15:0] vec [12] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
    16'h0023, 16'h002b, 16'h0053, 16'h0033, 16'h003b, 16'h0043, 16'h0063,
    16'h0073};
  int ord [12] = '{0, 5, 6, 1, 7, 2, 8, 10, 3, 9, 4, 11};
  logic [7:0] msk [7] = '{8'hff, 8'ha7, 8'hff, 8'hff, 8'ha7, 8'ha7, 8'h03};
  irq_ctrl dut (.CLK, .RST_B, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
    .EXT_IRQ_PIN_ZERO_N(~src[0]), .EXT_IRQ_PIN_ONE_N(~src[2]),
    .TIMER_ZERO_OVERFLOW_FLAG(src[1]), .TIMER_ONE_OVERFLOW_FLAG(src[3]),
    .SERIAL_TX_FLAG(src[4]), .SERIAL_RX_FLAG(rx), .BROWNOUT_FLAG(src[5]),
    .WATCHDOG_OVERFLOW_FLAG(src[6]), .SERIAL_BUS_ATTENTION_FLAG(src[7]),
    .KEYPAD_EVENT(src[8]), .COMPARATOR_TWO_FLAG(src[9]),
    .COMPARATOR_ONE_FLAG(src[10]), .TIMEOUT_TIMER_FLAG(src[11]), .IRQ_ACK,
    .IRQ_RETURN, .IRQ_REQ, .IRQ_VECTOR, .IRQ_LEVEL, .WAKE_REQ);
  core_model core (.CLK, .RST_B, .IRQ_REQ, .IRQ_VECTOR, .IRQ_ACK,
    .IRQ_RETURN, .take, .ret_go, .last_vec);
  // clock and hang ceiling
  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_fail++;
      conclude;
    end
  end
  // compare, bus cycles and handshake helpers
  task automatic chk(input logic [15:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR_EN <= 1'b1;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge CLK);
    WR_EN <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    RD_EN <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD_EN <= 1'b0;
    #1 v = RD_DATA;
  endtask
  task automatic put(input logic [11:0] s);
    @(posedge CLK);
    src <= s;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic ack;
    @(posedge CLK);
    take <= 1'b1;
    repeat (2) @(posedge CLK);
    take <= 1'b0;
    #1;
  endtask
  task automatic ret;
    @(posedge CLK);
    ret_go <= 1'b1;
    @(posedge CLK);
    ret_go <= 1'b0;
    wt(14);
  endtask
  // reset values, writable bits, unmapped offset 9
  task automatic t_regs;
    for (int a = 0; a < 10; a++)
    begin
      rd(a[3:0]);
      chk(v, 8'h00);
    end
    for (int a = 0; a < 7; a++)
    begin
      wr(a[3:0], 8'hff);
      rd(a[3:0]);
      chk(v, msk[a]);
      wr(a[3:0], 8'h00);
    end
  endtask
  // global and own enable gate a pending flag
  task automatic t_mask;
    wr(4'h0, 8'h7f);
    wr(4'h1, 8'ha7);
    put(12'h001);
    wt(14);
    chk(IRQ_REQ, 1'b0);
    rd(4'h7);
    chk(v, 8'h01);
    wr(4'h0, 8'hfe);
    wt(3);
    chk(IRQ_REQ, 1'b0);
    wr(4'h0, 8'hff);
    wt(3);
    chk(IRQ_REQ, 1'b1);
    put(12'h000);
    wt(14);
  endtask
  // each source alone: vector and wake
  task automatic t_alone;
    for (int i = 0; i < 12; i++)
    begin
      put(12'h001 << i);
      wt(14);
      chk(IRQ_VECTOR, vec[i]);
      chk(WAKE_REQ, (12'h765 >> i) & 12'h001);
      put(12'h000);
      wr(4'h7, 8'h04);
      wt(14);
    end
    // receive half of the serial source shares the serial vector
    @(posedge CLK);
    rx <= 1'b1;
    wt(14);
    chk(IRQ_REQ, 1'b1);
    chk(IRQ_VECTOR, 16'h0023);
    @(posedge CLK);
    rx <= 1'b0;
    wt(14);
  endtask
  // all twelve at one level, served in ranking order
  task automatic t_rank;
    put(12'hfff);
    put(12'heff);
    for (int k = 0; k < 12; k++)
    begin
      wt(14);
      chk(IRQ_VECTOR, vec[ord[k]]);
      ack;
      chk(last_vec, vec[ord[k]]);
      if (ord[k] == 8)
      begin
        rd(4'h7);
        chk(v, 8'h04);
        wr(4'h7, 8'h04);
      end
      put(src & ~(12'h001 << ord[k]));
      wt(14);
      chk(IRQ_REQ, (k == 11) ? 1'b0 : 1'b0);
      ret;
    end
  endtask
  // levels: higher first, preemption, top level blocks its own level
  task automatic t_prio;
    wr(4'h2, 8'h28);
    wr(4'h3, 8'h20);
    wr(4'h4, 8'h80);
    wr(4'h5, 8'h80);
    put(12'h00a);
    wt(14);
    chk(IRQ_VECTOR, 16'h001b);
    chk(IRQ_LEVEL, 2'h1);
    ack;
    put(12'h800);
    wt(14);
    chk(IRQ_VECTOR, 16'h0073);
    ack;
    rd(4'h8);
    chk(v, 8'h6a);
    put(12'h820);
    wt(14);
    chk(IRQ_REQ, 1'b0);
    put(12'h020);
    ret;
    chk(IRQ_VECTOR, 16'h002b);
    put(12'h000);
    ret;
    for (int a = 2; a < 6; a++)
      wr(a[3:0], 8'h00);
  endtask
  // edge then level trigger on external 0, pin held low through both modes
  task automatic t_edge;
    wr(4'h6, 8'h01);
    put(12'h001);
    wt(14);
    chk(IRQ_VECTOR, 16'h0003);
    ack;
    rd(4'h7);
    chk(v, 8'h00);
    ret;
    chk(IRQ_REQ, 1'b0);
    wr(4'h6, 8'h00);
    wt(14);
    chk(IRQ_REQ, 1'b1);
    ack;
    ret;
    chk(IRQ_REQ, 1'b1);
    put(12'h000);
    wt(14);
    chk(IRQ_REQ, 1'b0);
    // edge trigger on external 1
    wr(4'h6, 8'h02);
    put(12'h004);
    wt(14);
    chk(IRQ_VECTOR, 16'h0013);
    ack;
    ret;
    chk(IRQ_REQ, 1'b0);
    put(12'h000);
  endtask
  // counts and verdict
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // reset for 12 cycles, then the scenarios
  initial
  begin
    RST_B = 1'b0;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = 4'h0;
    WR_DATA = 8'h00;
    take = 1'b0;
    ret_go = 1'b0;
    src = 12'h000;
    rx = 1'b0;
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    t_regs;
    t_mask;
    t_alone;
    t_rank;
    t_prio;
    t_edge;
    conclude;
  end
endmodule // irq_ctrl_tb
`default_nettype wire
